/* design/sensor_cmd_defs.svh */
// command codes, configuration encodings and field positions of the command decoder
`ifndef SENSOR_CMD_DEFS_SVH
`define SENSOR_CMD_DEFS_SVH

// -----------------------------------------------------------------------------
// command codes
// -----------------------------------------------------------------------------
`define CMD_THR_SET_LOW   16'hE102
`define CMD_THR_SET_HIGH  16'hE11F
`define CMD_THR_CLR_LOW   16'hE109
`define CMD_THR_CLR_HIGH  16'hE114
`define CMD_OFFSET        16'hA004
`define CMD_SOFT_RESET    16'h30A2
`define CMD_SN_HI         16'h3683
`define CMD_SN_MID        16'h3684
`define CMD_SN_LO         16'h3685
`define CMD_MFR_ID        16'h3781
`define CMD_BOOT_CFG      16'h61BB
`define CMD_TRIG_LP0_A    16'h2400
`define CMD_TRIG_LP0_B    16'h2C06
`define CMD_TRIG_LP1_A    16'h240B
`define CMD_TRIG_LP1_B    16'h2C0D
`define CMD_TRIG_LP2_A    16'h2416
`define CMD_TRIG_LP2_B    16'h2C10
`define CMD_TRIG_LP3      16'h24FF
// command families decoded by neighbouring blocks
`define FWD_MSBS          8'h20, 8'h21, 8'h22, 8'h23, 8'h27, 8'h30, 8'hE0, 8'hF3, 8'h61

// -----------------------------------------------------------------------------
// boot configuration byte
// -----------------------------------------------------------------------------
`define CFG_FACTORY       8'h00
`define CRC_FACTORY       8'h81
`define CFG_LP            5:4
`define CFG_RATE          3:0
`define CFG_HI_NIBBLE     7:4
`define CFG_LP_MAX        4'h3
`define CFG_RATE_MIN      4'h3
`define CFG_RATE_MAX      4'hB
// checksums for rate codes 3,5,7,9,B, first entry in the top byte
`define CFG_CRC_LP0       40'hB0D2_7416_09
`define CFG_CRC_LP1       40'hF391_3755_4A
`define CFG_CRC_LP2       40'h3654_F290_8F
`define CFG_CRC_LP3       40'h7517_B1D3_CC

// -----------------------------------------------------------------------------
// trigger levels, serial number slices, payload counts
// -----------------------------------------------------------------------------
`define LP0               2'h0
`define LP1               2'h1
`define LP2               2'h2
`define LP3               2'h3
`define SN_HI             47:32
`define SN_MID            31:16
`define SN_LO             15:0
`define PAY_CFG_BYTES     2'h2
`define PAY_OFS_BYTES     2'h3
`define THR_SET_LOW       0
`define THR_SET_HIGH      1
`define THR_CLR_LOW       2
`define THR_CLR_HIGH      3

`endif

/* design/sensor_cmd_pkg.sv */
// types and shared helpers of the command decoder
`include "sensor_cmd_defs.svh"

package sensor_cmd_pkg;

    // -------------------------------------------------------------------------
    // decoder states
    // -------------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_MSB  = 4'b0010,
        ST_DATA = 4'b0100,
        ST_WAIT = 4'b1000
    } dec_state_e;

    // -------------------------------------------------------------------------
    // complete register state of the decoder
    // -------------------------------------------------------------------------
    typedef struct packed {
        dec_state_e       st;
        logic [7:0]       msb;
        logic [15:0]      code;
        logic [1:0]       pay_cnt;
        logic [7:0]       pay0;
        logic [7:0]       pay1;
        logic [15:0]      offset;
        logic [7:0]       cfg;
        logic [3:0][15:0] thr;
        logic             boot;
        logic             pin_meta;
        logic             pin_sync;
        logic             rsp_valid;
        logic [15:0]      rsp_word;
        logic             ack;
        logic             nack;
        logic             trig_valid;
        logic [1:0]       trig_lp;
        logic             fwd_valid;
        logic [15:0]      fwd_code;
        logic             auto_en;
        logic [1:0]       lp_level;
        logic [3:0]       rate;
        logic             dev_reset;
        logic             hist_reset;
        logic             off_wr;
        logic             cfg_wr;
    } dec_regs_s;

    // legal configuration byte: factory value, or level 0..3 with a listed rate
    function automatic logic cfg_known(input logic [7:0] cfg);
        logic [3:0] r;
        r = cfg[`CFG_RATE];
        cfg_known = (cfg == `CFG_FACTORY) ||
                    ((cfg[`CFG_HI_NIBBLE] <= `CFG_LP_MAX) && r[0] &&
                     (r >= `CFG_RATE_MIN) && (r <= `CFG_RATE_MAX));
    endfunction

endpackage

/* design/cfg_check.sv */
// checks a boot configuration byte against its checksum byte
`timescale 1ns/1ps
`include "sensor_cmd_defs.svh"

module cfg_check (
    // byte pair as received
    input  wire logic [7:0] cfg,
    input  wire logic [7:0] crc,
    // verdict
    output logic            pair_ok
);

    // -------------------------------------------------------------------------
    // checksum lookup
    // -------------------------------------------------------------------------
    logic [39:0] row;
    logic [2:0]  slot;
    logic [7:0]  exp_crc;

    // table row per power level, slot per rate code
    always_comb begin
        slot = 3'(cfg[`CFG_RATE] >> 1) - 3'h1;
        case (cfg[`CFG_LP])
            `LP0:    row = `CFG_CRC_LP0;
            `LP1:    row = `CFG_CRC_LP1;
            `LP2:    row = `CFG_CRC_LP2;
            default: row = `CFG_CRC_LP3;
        endcase
        exp_crc = 8'(row >> (6'(3'h4 - slot) * 6'h08));
        if (cfg == `CFG_FACTORY) begin
            exp_crc = `CRC_FACTORY;
        end
        // an unlisted byte fails even if its checksum happens to match
        pair_ok = sensor_cmd_pkg::cfg_known(cfg) && (crc == exp_crc);
    end

endmodule

/* design/sensor_cmd_decode_reset.sv */
// two-byte command decoder with soft, general-call and pin reset handling
//
// Summary of operation
// - commands arrive as two bytes, high byte first, decoded together as one code
// - E1 02/1F/09/14 return set-low, set-high, clear-low, clear-high thresholds
// - A0 04 with three payload bytes programs offsets, without payload reads them
// - 36 83/84/85 return serial number bytes 5-4, 3-2 and 1-0
// - 37 81 returns a fixed manufacturer word
// - trigger codes 2400/2C06, 240B/2C0D, 2416/2C10 act identically
// - 61 BB takes configuration and checksum; applied at every power-on and reset
// - configuration nibbles choose power level 0-3 and rate code 3,5,7,9,B
// - configuration 00 with checksum 81 restores sleep after reset
// - 30 A2 forces the default state without a supply interruption
// - soft reset acts exactly like power cycle or reset pin
// - soft reset clears status, reloads calibration and offsets, resets thresholds
// - general-call reset acts exactly as the soft reset command
// - after reset: sleep, or automatic measurement when an override is stored
// - every reset returns the min/max history to defaults
`timescale 1ns/1ps
`include "sensor_cmd_defs.svh"

module sensor_cmd_decode_reset #(
    parameter logic [15:0] MFR_ID       = 16'h5A5A, // arbitrary identification value
    parameter logic [15:0] THR_SET_LOW  = 16'h0000,
    parameter logic [15:0] THR_SET_HIGH = 16'hFFFF,
    parameter logic [15:0] THR_CLR_LOW  = 16'h0000,
    parameter logic [15:0] THR_CLR_HIGH = 16'hFFFF
) (
    // clock and power-on reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // external reset pin, asynchronous
    input  wire logic        reset_pin_n,
    // bytes from the bus target front end
    input  wire logic        wr_valid,
    input  wire logic        wr_first,
    input  wire logic [7:0]  wr_byte,
    input  wire logic        wr_stop,
    input  wire logic        gcall_reset,
    // non-volatile and fused contents
    input  wire logic [47:0] serial_number,
    input  wire logic [15:0] offset_nvm,
    input  wire logic [7:0]  cfg_nvm,
    // command answers
    output logic             ack,
    output logic             nack,
    output logic             rsp_valid,
    output logic [15:0]      rsp_word,
    output logic             trig_valid,
    output logic [1:0]       trig_lp,
    output logic             fwd_valid,
    output logic [15:0]      fwd_code,
    // measurement state after reset
    output logic             auto_en,
    output logic [1:0]       lp_level,
    output logic [3:0]       rate,
    // reset side effects and storage writes
    output logic             dev_reset,
    output logic             hist_reset,
    output logic             off_wr,
    output logic [15:0]      off_data,
    output logic             cfg_wr,
    output logic [7:0]       cfg_data
);

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    sensor_cmd_pkg::dec_regs_s q;
    sensor_cmd_pkg::dec_regs_s d;
    logic                      pair_ok;
    logic                      cmd_take;
    logic [15:0]               code_now;
    logic                      rst_any;
    logic                      soft_req;

    cfg_check u_cfg_check (
        .cfg     (q.pay0),
        .crc     (q.pay1),
        .pair_ok (pair_ok)
    );

    // second command byte completes the code
    assign cmd_take = wr_valid && !wr_first && (q.st == sensor_cmd_pkg::ST_MSB);
    assign code_now = {q.msb, wr_byte};
    // pin level is read only after both synchroniser stages
    assign rst_any  = q.boot || !q.pin_sync || gcall_reset;

    // -------------------------------------------------------------------------
    // next-state logic
    // -------------------------------------------------------------------------
    // one-cycle strobes fall back to zero unless set below
    always_comb begin
        d            = q;
        soft_req     = 1'b0;
        d.ack        = 1'b0;
        d.nack       = 1'b0;
        d.trig_valid = 1'b0;
        d.fwd_valid  = 1'b0;
        d.dev_reset  = 1'b0;
        d.hist_reset = 1'b0;
        d.off_wr     = 1'b0;
        d.cfg_wr     = 1'b0;
        d.pin_meta   = reset_pin_n;
        d.pin_sync   = q.pin_meta;
        if (wr_valid && wr_first) begin
            d.msb       = wr_byte;
            d.st        = sensor_cmd_pkg::ST_MSB;
            d.rsp_valid = 1'b0;
            d.pay_cnt   = 2'h0;
        end else if (wr_valid) begin
            case (q.st)
                sensor_cmd_pkg::ST_MSB: begin
                    d.code     = code_now;
                    d.st       = sensor_cmd_pkg::ST_WAIT;
                    d.ack      = 1'b1;
                    d.rsp_word = 16'h0000;
                    case (code_now)
                        `CMD_THR_SET_LOW:  d.rsp_word = q.thr[`THR_SET_LOW];
                        `CMD_THR_SET_HIGH: d.rsp_word = q.thr[`THR_SET_HIGH];
                        `CMD_THR_CLR_LOW:  d.rsp_word = q.thr[`THR_CLR_LOW];
                        `CMD_THR_CLR_HIGH: d.rsp_word = q.thr[`THR_CLR_HIGH];
                        `CMD_SN_HI:        d.rsp_word = serial_number[`SN_HI];
                        `CMD_SN_MID:       d.rsp_word = serial_number[`SN_MID];
                        `CMD_SN_LO:        d.rsp_word = serial_number[`SN_LO];
                        `CMD_MFR_ID:       d.rsp_word = MFR_ID;
                        default:           d.rsp_word = 16'h0000;
                    endcase
                    case (code_now)
                        `CMD_THR_SET_LOW, `CMD_THR_SET_HIGH, `CMD_THR_CLR_LOW,
                        `CMD_THR_CLR_HIGH, `CMD_SN_HI, `CMD_SN_MID, `CMD_SN_LO,
                        `CMD_MFR_ID: begin
                            d.rsp_valid = 1'b1;
                        end
                        `CMD_OFFSET, `CMD_BOOT_CFG: begin
                            d.st = sensor_cmd_pkg::ST_DATA;
                        end
                        `CMD_SOFT_RESET: begin
                            soft_req = 1'b1;
                        end
                        // paired codes share one level, so either one triggers alike
                        `CMD_TRIG_LP0_A, `CMD_TRIG_LP0_B: begin
                            d.trig_valid = 1'b1;
                            d.trig_lp    = `LP0;
                        end
                        `CMD_TRIG_LP1_A, `CMD_TRIG_LP1_B: begin
                            d.trig_valid = 1'b1;
                            d.trig_lp    = `LP1;
                        end
                        `CMD_TRIG_LP2_A, `CMD_TRIG_LP2_B: begin
                            d.trig_valid = 1'b1;
                            d.trig_lp    = `LP2;
                        end
                        `CMD_TRIG_LP3: begin
                            d.trig_valid = 1'b1;
                            d.trig_lp    = `LP3;
                        end
                        default: begin
                            case (q.msb)
                                `FWD_MSBS: begin
                                    d.fwd_valid = 1'b1;
                                    d.fwd_code  = code_now;
                                end
                                default: begin
                                    d.ack  = 1'b0;
                                    d.nack = 1'b1;
                                    d.code = q.code;
                                    d.st   = sensor_cmd_pkg::ST_IDLE;
                                end
                            endcase
                        end
                    endcase
                end
                sensor_cmd_pkg::ST_DATA: begin
                    if (q.pay_cnt == 2'h0) begin
                        d.pay0 = wr_byte;
                    end
                    if (q.pay_cnt == 2'h1) begin
                        d.pay1 = wr_byte;
                    end
                    // the trailing offset checksum byte is counted, not kept
                    if (q.pay_cnt == `PAY_OFS_BYTES) begin
                        d.nack = 1'b1;
                    end else begin
                        d.ack     = 1'b1;
                        d.pay_cnt = 2'(q.pay_cnt + 2'h1);
                    end
                end
                default: begin
                    d.nack = 1'b1;
                end
            endcase
        end
        // payload is judged when the write transaction ends
        if (wr_stop && (q.st == sensor_cmd_pkg::ST_DATA)) begin
            d.st = sensor_cmd_pkg::ST_IDLE;
            if (q.code == `CMD_BOOT_CFG) begin
                if (q.pay_cnt == `PAY_CFG_BYTES && pair_ok) begin
                    d.cfg    = q.pay0;
                    d.cfg_wr = 1'b1;
                end else begin
                    d.nack = 1'b1;
                end
            end else if (q.pay_cnt == 2'h0) begin
                d.rsp_valid = 1'b1;
                d.rsp_word  = q.offset;
            end else if (q.pay_cnt == `PAY_OFS_BYTES) begin
                d.offset = {q.pay0, q.pay1};
                d.off_wr = 1'b1;
            end else begin
                d.nack = 1'b1;
            end
        end
        // every reset source runs the same sequence
        if (rst_any || soft_req) begin
            d.thr        = {THR_CLR_HIGH, THR_CLR_LOW, THR_SET_HIGH, THR_SET_LOW};
            d.offset     = offset_nvm;
            d.cfg        = cfg_nvm;
            d.auto_en    = sensor_cmd_pkg::cfg_known(cfg_nvm) &&
                           (cfg_nvm != `CFG_FACTORY);
            d.lp_level   = d.auto_en ? cfg_nvm[`CFG_LP] : `LP0;
            d.rate       = d.auto_en ? cfg_nvm[`CFG_RATE] : 4'h0;
            d.dev_reset  = 1'b1;
            d.hist_reset = 1'b1;
            d.rsp_valid  = 1'b0;
            d.st         = sensor_cmd_pkg::ST_IDLE;
            d.boot       = 1'b0;
        end
    end

    // state register; boot flag makes the first clock load stored contents
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q          <= '0;
            q.st       <= sensor_cmd_pkg::ST_IDLE;
            q.boot     <= 1'b1;
            q.pin_meta <= 1'b1;
            q.pin_sync <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign ack        = q.ack;
    assign nack       = q.nack;
    assign rsp_valid  = q.rsp_valid;
    assign rsp_word   = q.rsp_word;
    assign trig_valid = q.trig_valid;
    assign trig_lp    = q.trig_lp;
    assign fwd_valid  = q.fwd_valid;
    assign fwd_code   = q.fwd_code;
    assign auto_en    = q.auto_en;
    assign lp_level   = q.lp_level;
    assign rate       = q.rate;
    assign dev_reset  = q.dev_reset;
    assign hist_reset = q.hist_reset;
    assign off_wr     = q.off_wr;
    assign off_data   = q.offset;
    assign cfg_wr     = q.cfg_wr;
    assign cfg_data   = q.cfg;

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_thr_readback: assert property (cmd_take && !rst_any && code_now == `CMD_THR_SET_HIGH
        |=> rsp_valid && rsp_word == q.thr[`THR_SET_HIGH])
        else $error("threshold readback wrong");
    a_offset_program: assert property (wr_stop && q.st == sensor_cmd_pkg::ST_DATA
        && q.code == `CMD_OFFSET && q.pay_cnt == `PAY_OFS_BYTES && !rst_any
        |=> off_wr && off_data == {$past(q.pay0), $past(q.pay1)})
        else $error("offset not programmed");
    a_serial_lo: assert property (cmd_take && !rst_any && code_now == `CMD_SN_LO
        |=> rsp_valid && rsp_word == $past(serial_number[`SN_LO]))
        else $error("serial low word wrong");
    a_mfr_word: assert property (cmd_take && !rst_any && code_now == `CMD_MFR_ID
        |=> rsp_valid && rsp_word == MFR_ID ##1 !ack)
        else $error("manufacturer word wrong");
    a_trig_pair: assert property (cmd_take && !rst_any && code_now == `CMD_TRIG_LP1_B
        |=> trig_valid && trig_lp == `LP1 && !fwd_valid)
        else $error("trigger pair not equivalent");
    a_cfg_reject: assert property (wr_stop && q.st == sensor_cmd_pkg::ST_DATA
        && q.code == `CMD_BOOT_CFG && !pair_ok && !rst_any
        |=> nack && !cfg_wr && $stable(cfg_data))
        else $error("bad configuration accepted");
    a_soft_reset: assert property (cmd_take && code_now == `CMD_SOFT_RESET
        |=> dev_reset && hist_reset && q.thr[`THR_SET_LOW] == THR_SET_LOW && !rsp_valid)
        else $error("soft reset incomplete");
    a_gcall_reset: assert property (gcall_reset
        |=> dev_reset && off_data == $past(offset_nvm) ##1 !dev_reset || $past(gcall_reset))
        else $error("general call reset ignored");
    a_boot_sleep: assert property (dev_reset && cfg_data == `CFG_FACTORY
        |-> !auto_en && rate == 4'h0)
        else $error("factory configuration not sleeping");
    a_unknown_nack: assert property (cmd_take && !rst_any && code_now[15:8] == 8'h99
        |=> nack && !ack && $stable(auto_en) && $stable(cfg_data))
        else $error("unknown code acknowledged");

    c_cfg_accept:  cover property (cfg_wr ##1 !nack);
    c_soft_reset:  cover property (cmd_take && code_now == `CMD_SOFT_RESET);
    c_offset_read: cover property (rsp_valid && q.code == `CMD_OFFSET);
    c_pin_reset:   cover property (!q.pin_sync ##1 q.pin_sync);

endmodule

/* verification/i2c_host_model.sv */
// bus controller model that hands command and payload bytes to the decoder
`timescale 1ns/1ps

module i2c_host_model (
    // clock
    input  wire logic       ref_clk,
    // byte stream towards the decoder
    output logic            wr_valid,
    output logic            wr_first,
    output logic [7:0]      wr_byte,
    output logic            wr_stop
);
    // ---------------------------------------------------------------------
    // idle bus at time zero
    // ---------------------------------------------------------------------
    initial begin
        wr_valid = 1'b0;
        wr_first = 1'b0;
        wr_byte  = 8'h00;
        wr_stop  = 1'b0;
    end

    // one byte, launched just after an edge and held for one cycle
    task automatic put(input logic first, input logic [7:0] b);
        @(posedge ref_clk);
        wr_valid <= 1'b1;
        wr_first <= first;
        wr_byte  <= b;
    endtask

    // end of write; the lane stops showing the last byte
    task automatic stop();
        @(posedge ref_clk);
        wr_valid <= 1'b0;
        wr_first <= 1'b0;
        wr_byte  <= ~wr_byte;
        wr_stop  <= 1'b1;
        @(posedge ref_clk);
        wr_stop  <= 1'b0;
    endtask

    // code high byte first, then up to three payload bytes, top byte first
    task automatic xfer(input logic [15:0] code, input int n, input logic [23:0] pay);
        put(1'b1, code[15:8]);
        put(1'b0, code[7:0]);
        for (int i = 0; i < n; i++) begin
            put(1'b0, pay[23-8*i -: 8]);
        end
        stop();
    endtask
endmodule

/* verification/tb_sensor_cmd_decode_reset.sv */
// self-checking testbench of the command decoder
`timescale 1ns/1ps

module tb_sensor_cmd_decode_reset;
    logic ref_clk, sys_rst, reset_pin_n, gcall_reset;
    logic wr_valid, wr_first, wr_stop;
    logic [7:0]  wr_byte, cfg_nvm, cfg_data;
    logic [47:0] serial_number;
    logic [15:0] offset_nvm, rsp_word, fwd_code, off_data;
    logic ack, nack, rsp_valid, trig_valid, fwd_valid, auto_en;
    logic dev_reset, hist_reset, off_wr, cfg_wr;
    logic [1:0]  trig_lp, lp_level;
    logic [3:0]  rate;
    int errors, compares, cycles;
    logic ack_seen, nack_seen, trig_seen, fwd_seen, dev_seen, hist_seen;

    // distinct thresholds so a swapped readback slot shows up
    sensor_cmd_decode_reset #(.THR_SET_LOW(16'h1001), .THR_SET_HIGH(16'hF00F),
        .THR_CLR_LOW(16'h2002), .THR_CLR_HIGH(16'hE00E)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reset_pin_n(reset_pin_n), .wr_valid(wr_valid), .wr_first(wr_first),
        .wr_byte(wr_byte), .wr_stop(wr_stop), .gcall_reset(gcall_reset),
        .serial_number(serial_number), .offset_nvm(offset_nvm), .cfg_nvm(cfg_nvm),
        .ack(ack), .nack(nack), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
        .trig_valid(trig_valid), .trig_lp(trig_lp), .fwd_valid(fwd_valid),
        .fwd_code(fwd_code), .auto_en(auto_en), .lp_level(lp_level), .rate(rate),
        .dev_reset(dev_reset), .hist_reset(hist_reset), .off_wr(off_wr),
        .off_data(off_data), .cfg_wr(cfg_wr), .cfg_data(cfg_data));
    i2c_host_model i_host (.ref_clk(ref_clk), .wr_valid(wr_valid), .wr_first(wr_first),
        .wr_byte(wr_byte), .wr_stop(wr_stop));

    // -------------------------------------------------------------------------
    // clock and hang guard; ceiling is far above the roughly 120 cycles needed
    // -------------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end

    // compare one result
    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // two-byte command; one-cycle answers are caught the cycle after the code byte
    task automatic send_cmd(input logic [15:0] code);
        fork
            i_host.xfer(code, 0, 24'h00_0000);
            begin
                repeat (3) @(posedge ref_clk);
                #1;
                ack_seen  = ack;
                nack_seen = nack;
                trig_seen = trig_valid;
                fwd_seen  = fwd_valid;
                dev_seen  = dev_reset;
                hist_seen = hist_reset;
            end
        join
    endtask

    // bounded wait for the reset sequence pulse, sampled after edges settle
    task automatic wait_reset();
        #1;
        for (int i = 0; i < 6 && dev_reset !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("dev_reset", 1, dev_reset);
        chk("hist_reset", 1, hist_reset);
    endtask

    task automatic report_and_stop();
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // first edge after release runs the reset sequence with sleep default
    task automatic t_power_on();
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("por dev_reset", 1, dev_reset);
        chk("por hist_reset", 1, hist_reset);
        chk("por off_data", 16'h1234, off_data);
        chk("por auto_en", 0, auto_en);
    endtask

    // serial slices, maker word and the four threshold readbacks
    task automatic t_reads();
        logic [15:0] c [8] = '{16'h3683, 16'h3684, 16'h3685, 16'h3781,
                               16'hE102, 16'hE11F, 16'hE109, 16'hE114};
        logic [15:0] e [8] = '{16'h0123, 16'h4567, 16'h89AB, 16'h5A5A,
                               16'h1001, 16'hF00F, 16'h2002, 16'hE00E};
        for (int i = 0; i < 8; i++) begin
            send_cmd(c[i]);
            #1;
            chk("read ack", 1, ack_seen);
            chk("read rsp_word", e[i], rsp_word);
            chk("read rsp_valid", 1, rsp_valid);
        end
    endtask

    // both codes of each on-demand pair give the same level
    task automatic t_trigger();
        logic [15:0] c [6] = '{16'h2400, 16'h2C06, 16'h240B, 16'h2C0D, 16'h2416, 16'h2C10};
        for (int i = 0; i < 6; i++) begin
            send_cmd(c[i]);
            #1;
            chk("trig_valid", 1, trig_seen);
            chk("trig_lp", i / 2, trig_lp);
        end
        send_cmd(16'h2032);
        #1;
        chk("fwd_valid", 1, fwd_seen);
        chk("fwd_code", 16'h2032, fwd_code);
    endtask

    // boot override: good pair, bad checksum, unlisted byte, factory pair
    task automatic t_boot_cfg();
        logic [15:0] p [4] = '{16'h03B0, 16'h0500, 16'h0435, 16'h0081};
        logic [7:0]  d [4] = '{8'h03, 8'h03, 8'h03, 8'h00};
        for (int i = 0; i < 4; i++) begin
            i_host.xfer(16'h61BB, 2, {p[i], 8'h00});
            #1;
            chk("cfg_wr", (i == 0 || i == 3), cfg_wr);
            chk("cfg nack", (i == 1 || i == 2), nack);
            chk("cfg_data", d[i], cfg_data);
        end
    endtask

    // offset program then readback
    task automatic t_offset();
        i_host.xfer(16'hA004, 3, 24'h5678_9A);
        #1;
        chk("off_wr", 1, off_wr);
        chk("off_data", 16'h5678, off_data);
        i_host.xfer(16'hA004, 0, 24'h00_0000);
        @(posedge ref_clk);
        #1;
        chk("offset read", 16'h5678, rsp_word);
    endtask

    // soft reset reloads offsets and applies the stored override
    task automatic t_soft_reset();
        cfg_nvm <= 8'h3B;
        send_cmd(16'h30A2);
        chk("soft dev_reset", 1, dev_seen);
        chk("soft hist_reset", 1, hist_seen);
        @(posedge ref_clk);
        #1;
        chk("soft off_data", 16'h1234, off_data);
        chk("soft auto_en", 1, auto_en);
        chk("soft lp_level", 3, lp_level);
        chk("soft rate", 4'hB, rate);
    endtask

    // general call, reset pin, then an unknown code
    task automatic t_other_resets();
        @(posedge ref_clk);
        gcall_reset <= 1'b1;
        @(posedge ref_clk);
        gcall_reset <= 1'b0;
        wait_reset();
        @(posedge ref_clk);
        reset_pin_n <= 1'b0;
        wait_reset();
        @(posedge ref_clk);
        reset_pin_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        send_cmd(16'h9955);
        #1;
        chk("unknown nack", 1, nack_seen);
        chk("unknown ack", 0, ack_seen);
        chk("unknown auto_en", 1, auto_en);
    endtask

    // -------------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------------
    initial begin
        sys_rst       = 1'b1;
        reset_pin_n   = 1'b1;
        gcall_reset   = 1'b0;
        serial_number = 48'h0123_4567_89AB;
        offset_nvm    = 16'h1234;
        cfg_nvm       = 8'h00;
        repeat (3) @(posedge ref_clk);
        t_power_on();
        t_reads();
        t_trigger();
        t_boot_cfg();
        t_offset();
        t_soft_reset();
        t_other_resets();
        report_and_stop();
    end
endmodule
